// ==== rtl/npic_pkg.sv ====
// package: constants and carrier types of the nested priority interrupt controller
package npic_pkg;

  // ---------------------------------------------------------------
  // vector map and counts
  // ---------------------------------------------------------------
  localparam int NUM_VEC = 16;
  localparam int NUM_MASKABLE = 14;
  localparam logic [15:0] VEC_BASE = 16'hffe0;
  localparam logic [15:0] VEC_TOP = 16'hffff;
  localparam logic [15:0] VEC_RESET = 16'hfffe;
  localparam logic [15:0] VEC_TRAP = 16'hfffc;
  localparam logic [15:0] VEC_MASK0 = 16'hfffa;

  // ---------------------------------------------------------------
  // condition code layout and levels
  // ---------------------------------------------------------------
  localparam int CC_HI_POS = 5;
  localparam int CC_LO_POS = 3;
  localparam logic [7:0] CC_RESET = 8'hea;
  localparam logic [1:0] LVL0_CODE = 2'b10;
  localparam logic [1:0] LVL1_CODE = 2'b01;
  localparam logic [1:0] LVL2_CODE = 2'b00;
  localparam logic [1:0] LVL3_CODE = 2'b11;
  localparam logic [7:0] PRIO_RESET = 8'hff;
  localparam logic [3:0] PRIO3_RO = 4'hf;

  // ---------------------------------------------------------------
  // sequencer states, one-hot
  // ---------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_RUN   = 6'b000001,
    ST_PUSH  = 6'b000010,
    ST_VEC   = 6'b000100,
    ST_POP   = 6'b001000,
    ST_WAIT  = 6'b010000,
    ST_HALT  = 6'b100000
  } npic_state_t;

  // core instruction strobes
  typedef struct packed {
    logic done;
    logic unmask;
    logic mask;
    logic waiti;
    logic halt;
    logic int_return_instr;
    logic trap;
    logic pop_cc;
  } npic_instr_t;

  // whole state of the controller
  typedef struct packed {
    npic_state_t st;
    logic [7:0] cc;
    logic [NUM_MASKABLE*2-1:0] prio;
    logic [NUM_MASKABLE-1:0] edge_pend;
    logic [NUM_MASKABLE-1:0] ext_d;
    logic [NUM_MASKABLE-1:0] ext_s1;
    logic [NUM_MASKABLE-1:0] ext_s2;
    logic [NUM_MASKABLE-1:0] ext_s3;
    logic [1:0] step;
    logic [3:0] sel;
    logic sel_nmi;
    logic reset_entry;
    logic [15:0] vec_addr;
    logic entry;
    logic [1:0] push_idx;
  } npic_reg_t;

endpackage

// ==== rtl/npic_top.sv ====
// nested priority interrupt controller beside an 8-bit core
// Function
// - four software levels, sixteen fixed vectors, reset and trap non-maskable.
// - current level kept in cc bits 5 and 3.
// - levels encode 10,01,00,11; level 3 blocks maskable requests.
// - vectors lie from ffe0 to ffff in hardware priority order.
// - entry waits for the current instruction to finish.
// - entry pushes pc, x, a and cc onto the stack.
// - maskable entry loads level from priority registers, then pc from vector.
// - interrupt return restores stacked cc with its level bits.
// - highest software level wins; ties go to highest hardware priority.
// - unserviced edge requests stay latched until they rank highest.
// - maskable request taken only if enabled and above current level.
// - reset and trap outrank every software level.
// - non-maskable entry ignores level, stacks except reset, sets level 3.
// - trap instruction raises the software non-maskable interrupt.
// - cc resets to 111x 1010.
// - edge external requests latch and clear on handler entry.
// - enabled pins sharing an external line are ORed.
// - peripheral request is flag and enable together.
// - peripheral clear sequence drops its request latch.
// - any request wakes from wait; only wake-capable ones wake from halt.
// - halt exit serves best wake-capable first, then higher ones.
// - unmask, mask, halt, wait, return and cc pop change the level.
// - writing level 0 code into a priority field keeps old value.
// - priority registers reset to all ones.
`timescale 1ns/1ps
module npic_top
  import npic_pkg::*;
#(
  parameter int NUM_EXT_PINS = 4,
  parameter logic [NUM_MASKABLE-1:0] HALT_WAKE = 14'h00bf,
  parameter logic [NUM_MASKABLE-1:0] EXT_LINES = 14'h001e
) (
  input wire logic SYS_CLK,
  input wire logic RST_B,
  // peripheral flags and enables, one per maskable vector
  input wire logic [NUM_MASKABLE-1:0] PERIPH_FLAG,
  input wire logic [NUM_MASKABLE-1:0] PERIPH_EN,
  // external pins per maskable vector and their pin enables
  input wire logic [NUM_MASKABLE*NUM_EXT_PINS-1:0] EXT_PIN,
  input wire logic [NUM_MASKABLE*NUM_EXT_PINS-1:0] EXT_PIN_EN,
  input wire logic [NUM_MASKABLE-1:0] EXT_EDGE_MODE,
  // core instruction strobes and data
  input wire npic_pkg::npic_instr_t INSTR,
  input wire logic [7:0] CC_POP_DATA,
  // software priority register writes
  input wire logic PRIO_WE,
  input wire logic [1:0] PRIO_IDX,
  input wire logic [7:0] PRIO_WDATA,
  output logic [7:0] PRIO_RDATA,
  // to the core
  output logic [7:0] CC,
  output logic STALL,
  output logic PUSH_REQ,
  output logic [1:0] PUSH_SEL,
  output logic VEC_LOAD,
  output logic [15:0] VEC_ADDR,
  output logic SLEEPING,
  output logic [NUM_MASKABLE-1:0] PEND
);

  npic_reg_t r;
  npic_reg_t next_r;
  logic [NUM_MASKABLE-1:0] ext_or;
  logic [NUM_MASKABLE-1:0] req;
  logic [NUM_MASKABLE-1:0] cand;
  logic [NUM_MASKABLE-1:0] wake_cand;
  logic [3:0] best;
  logic best_ok;
  logic [3:0] wbest;
  logic wbest_ok;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // map the level code onto a rank 0..3
  function automatic logic [1:0] lvl_rank(input logic [1:0] code);
    case (code)
      LVL0_CODE: lvl_rank = 2'd0;
      LVL1_CODE: lvl_rank = 2'd1;
      LVL2_CODE: lvl_rank = 2'd2;
      default: lvl_rank = 2'd3;
    endcase
  endfunction

  // current level as hi/lo code
  function automatic logic [1:0] cc_lvl(input logic [7:0] c);
    cc_lvl = {c[CC_HI_POS], c[CC_LO_POS]};
  endfunction

  // place a level code into cc
  function automatic logic [7:0] cc_set(input logic [7:0] c, input logic [1:0] code);
    logic [7:0] v;
    v = c;
    v[CC_HI_POS] = code[1];
    v[CC_LO_POS] = code[0];
    cc_set = v;
  endfunction

  // vector address of maskable index: fffa downward by two
  function automatic logic [15:0] vec_of(input logic [3:0] idx);
    vec_of = VEC_MASK0 - {11'h000, idx, 1'b0};
  endfunction

  // ---------------------------------------------------------------
  // request gathering
  // ---------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < NUM_MASKABLE; i++) begin
      ext_or[i] = 1'b0;
      for (int p = 0; p < NUM_EXT_PINS; p++) begin
        ext_or[i] = ext_or[i] | (EXT_PIN[i*NUM_EXT_PINS+p] & EXT_PIN_EN[i*NUM_EXT_PINS+p]);
      end
    end
  end

  // peripheral requests come straight from flag and enable, so the clear drops them
  always_comb begin
    for (int i = 0; i < NUM_MASKABLE; i++) begin
      if (EXT_LINES[i] && EXT_EDGE_MODE[i]) begin
        req[i] = r.edge_pend[i];
      end else if (EXT_LINES[i]) begin
        req[i] = r.ext_s3[i];
      end else begin
        req[i] = PERIPH_FLAG[i] & PERIPH_EN[i];
      end
    end
  end

  // ---------------------------------------------------------------
  // arbitration: software rank first, lowest index wins ties
  // ---------------------------------------------------------------
  always_comb begin
    logic [1:0] cur;
    logic [1:0] brank;
    logic [1:0] wrank;
    logic [1:0] rk;
    cur = lvl_rank(cc_lvl(r.cc));
    best = 4'd0;
    best_ok = 1'b0;
    brank = 2'd0;
    wbest = 4'd0;
    wbest_ok = 1'b0;
    wrank = 2'd0;
    rk = 2'd0;
    for (int i = 0; i < NUM_MASKABLE; i++) begin
      rk = lvl_rank(r.prio[2*i +: 2]);
      cand[i] = req[i] && (rk > cur);
      wake_cand[i] = req[i] && HALT_WAKE[i] && (rk > cur);
    end
    // scan high index first so greater-or-equal lets the lower index win ties
    for (int i = NUM_MASKABLE - 1; i >= 0; i--) begin
      rk = lvl_rank(r.prio[2*i +: 2]);
      if (cand[i] && (!best_ok || rk >= brank)) begin
        best = 4'(i);
        brank = rk;
        best_ok = 1'b1;
      end
      if (wake_cand[i] && (!wbest_ok || rk >= wrank)) begin
        wbest = 4'(i);
        wrank = rk;
        wbest_ok = 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [7:0] w;
    logic [7:0] old;
    logic [31:0] pr;
    w = 8'h00;
    old = 8'h00;
    // the last register is only half backed by flops; widen so every index is in range
    pr = {PRIO3_RO, r.prio};
    next_r = r;
    next_r.entry = 1'b0;
    // three-stage synchroniser; first and second agreeing means a settled level
    next_r.ext_s1 = ext_or;
    next_r.ext_s2 = r.ext_s1;
    next_r.ext_s3 = (r.ext_s2 == r.ext_s1) ? r.ext_s2 : r.ext_s3;
    next_r.ext_d = r.ext_s3;
    for (int i = 0; i < NUM_MASKABLE; i++) begin
      if (r.ext_s3[i] && !r.ext_d[i] && EXT_LINES[i] && EXT_EDGE_MODE[i]) begin
        next_r.edge_pend[i] = 1'b1;
      end
    end
    // priority register writes; top nibble of the last one stays ones
    if (PRIO_WE) begin
      old = pr[8*PRIO_IDX +: 8];
      w = PRIO_WDATA;
      for (int f = 0; f < 4; f++) begin
        if (w[2*f +: 2] == LVL0_CODE) begin
          w[2*f +: 2] = old[2*f +: 2];
        end
      end
      pr[8*PRIO_IDX +: 8] = w;
      pr[31:28] = PRIO3_RO;
      next_r.prio = pr[NUM_MASKABLE*2-1:0];
    end
    case (r.st)
      ST_RUN: begin
        // only act at instruction boundaries
        if (INSTR.done) begin
          if (INSTR.trap) begin
            next_r.sel_nmi = 1'b1;
            next_r.st = ST_PUSH;
            next_r.step = 2'd0;
          end else if (INSTR.int_return_instr) begin
            next_r.st = ST_POP;
          end else if (INSTR.pop_cc) begin
            next_r.cc = CC_POP_DATA;
          end else if (INSTR.unmask) begin
            next_r.cc = cc_set(r.cc, LVL0_CODE);
          end else if (INSTR.mask) begin
            next_r.cc = cc_set(r.cc, LVL3_CODE);
          end else if (INSTR.waiti) begin
            next_r.cc = cc_set(r.cc, LVL0_CODE);
            next_r.st = ST_WAIT;
          end else if (INSTR.halt) begin
            next_r.cc = cc_set(r.cc, LVL0_CODE);
            next_r.st = ST_HALT;
          end else if (best_ok) begin
            next_r.sel = best;
            next_r.sel_nmi = 1'b0;
            next_r.st = ST_PUSH;
            next_r.step = 2'd0;
          end
        end
      end
      ST_WAIT: begin
        if (best_ok) begin
          next_r.sel = best;
          next_r.sel_nmi = 1'b0;
          next_r.st = ST_PUSH;
          next_r.step = 2'd0;
        end
      end
      ST_HALT: begin
        if (wbest_ok) begin
          next_r.sel = wbest;
          next_r.sel_nmi = 1'b0;
          next_r.st = ST_PUSH;
          next_r.step = 2'd0;
        end
      end
      ST_PUSH: begin
        // pc, x, a, cc in that order; no depth check on the stack
        next_r.step = r.step + 2'd1;
        if (r.step == 2'd3) begin
          next_r.st = ST_VEC;
        end
      end
      ST_VEC: begin
        next_r.entry = 1'b1;
        next_r.reset_entry = 1'b0;
        next_r.st = ST_RUN;
        if (r.sel_nmi || r.reset_entry) begin
          next_r.cc = cc_set(r.cc, LVL3_CODE);
          next_r.vec_addr = r.reset_entry ? VEC_RESET : VEC_TRAP;
          next_r.sel_nmi = 1'b0;
        end else begin
          next_r.cc = cc_set(r.cc, r.prio[2*r.sel +: 2]);
          next_r.vec_addr = vec_of(r.sel);
          next_r.edge_pend[r.sel] = 1'b0;
        end
      end
      ST_POP: begin
        next_r.cc = CC_POP_DATA;
        next_r.st = ST_RUN;
      end
      default: begin
        next_r.st = ST_RUN;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // state register; reset enters through the vector stage unstacked
  // ---------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      r <= '0;
      r.st <= ST_VEC;
      r.reset_entry <= 1'b1;
      r.cc <= CC_RESET;
      r.prio <= {(NUM_MASKABLE*2){1'b1}};
      r.vec_addr <= VEC_TOP;
    end else begin
      r <= next_r;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  always_comb begin
    logic [31:0] full;
    full = {PRIO3_RO, r.prio};
    PRIO_RDATA = full[8*PRIO_IDX +: 8];
  end
  assign CC = r.cc;
  assign STALL = (r.st != ST_RUN);
  assign PUSH_REQ = (r.st == ST_PUSH);
  assign PUSH_SEL = r.step;
  assign VEC_LOAD = r.entry;
  assign VEC_ADDR = r.vec_addr;
  assign SLEEPING = (r.st == ST_WAIT) || (r.st == ST_HALT);
  assign PEND = req;

endmodule

// ==== test/npic_monitor.sv ====
// checker: port-level timing of the interrupt controller
`timescale 1ns/1ps
module npic_monitor
  import npic_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RST_B,
  input wire npic_pkg::npic_instr_t INSTR,
  input wire logic [7:0] CC_POP_DATA,
  input wire logic [7:0] CC,
  input wire logic STALL,
  input wire logic PUSH_REQ,
  input wire logic [1:0] PUSH_SEL,
  input wire logic VEC_LOAD,
  input wire logic [15:0] VEC_ADDR,
  input wire logic SLEEPING
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_B);
  // instruction accepted at this edge
  logic take;
  logic lvl3;
  assign take = !STALL && INSTR.done;
  assign lvl3 = CC[CC_HI_POS] && CC[CC_LO_POS];
  // stacking walk, then the vector stage
  sequence s_stack;
    PUSH_SEL == 2'd0 ##1 PUSH_SEL == 2'd1 ##1 PUSH_SEL == 2'd2 ##1 PUSH_SEL == 2'd3;
  endsequence
  sequence s_load;
    !PUSH_REQ && STALL ##1 VEC_LOAD && !STALL;
  endsequence
  a_stack_order: assert property ($rose(PUSH_REQ) |-> s_stack)
    else $error("stack order wrong");
  a_entry_walk: assert property ($rose(PUSH_REQ) |-> PUSH_REQ [*4] ##1 s_load)
    else $error("entry timing wrong");
  a_vec_map: assert property (VEC_LOAD |-> VEC_ADDR >= VEC_BASE && !VEC_ADDR[0])
    else $error("vector outside map");
  a_nmi_level: assert property (VEC_LOAD && VEC_ADDR >= VEC_TRAP |-> lvl3)
    else $error("nmi level not 3");
  a_trap_take: assert property (take && INSTR == 8'h82 |=> PUSH_REQ)
    else $error("trap not stacked");
  a_level3_hold: assert property (!STALL && lvl3 && INSTR != 8'h82 |=> !PUSH_REQ)
    else $error("entry at level 3");
  a_int_return_instr_cc: assert property (take && INSTR == 8'h84 |-> ##[2:3] CC == CC_POP_DATA)
    else $error("return cc wrong");
  a_mask_lvl: assert property (take && INSTR == 8'ha0 |=> lvl3)
    else $error("mask level wrong");
  a_unmask_lvl: assert property (take && INSTR == 8'hc0 |=> {CC[5], CC[3]} == LVL0_CODE)
    else $error("unmask level wrong");
  a_sleep_entry: assert property (take && (INSTR == 8'h90 || INSTR == 8'h88)
    |=> SLEEPING && {CC[5], CC[3]} == LVL0_CODE)
    else $error("sleep entry wrong");
endmodule

bind npic_top npic_monitor npic_monitor_i (
  .SYS_CLK(SYS_CLK),
  .RST_B(RST_B),
  .INSTR(INSTR),
  .CC_POP_DATA(CC_POP_DATA),
  .CC(CC),
  .STALL(STALL),
  .PUSH_REQ(PUSH_REQ),
  .PUSH_SEL(PUSH_SEL),
  .VEC_LOAD(VEC_LOAD),
  .VEC_ADDR(VEC_ADDR),
  .SLEEPING(SLEEPING)
);

// ==== test/npic_core_mdl.sv ====
// core model: issues one instruction strobe per call
`timescale 1ns/1ps
module npic_core_mdl
  import npic_pkg::*;
(
  input wire logic clk,
  input wire logic stall,
  output npic_pkg::npic_instr_t instr
);
  int gap = 0;
  initial instr = '0;
  // stall is read mid-cycle so the sample never races its own edge
  task automatic exec(input logic [7:0] op);
    repeat (gap) @(posedge clk);
    @(negedge clk);
    while (stall) @(negedge clk);
    @(posedge clk);
    instr <= npic_instr_t'(op | 8'h80);
    @(posedge clk);
    instr <= '0;
  endtask
endmodule

// ==== test/test_npic_top.sv ====
// testbench: directed scenarios for the interrupt controller
`timescale 1ns/1ps
module test_npic_top;
  import npic_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [13:0] flag = '0;
  logic [13:0] en = '0;
  logic [55:0] pin = '0;
  logic [55:0] pin_en = '0;
  logic [13:0] edge_md = '0;
  logic [7:0] pop_cc = 8'he2;
  logic we = 1'b0;
  logic [1:0] idx = '0;
  logic [7:0] wdata = '0;
  logic [7:0] rdata, cc;
  logic stall, push, vload, sleeping;
  logic [1:0] psel;
  logic [15:0] vaddr, a;
  logic [13:0] pend;
  npic_instr_t instr;
  int err_total = 0;
  int checks = 0;
  always #4 sys_clk = ~sys_clk;
  npic_top npic_top_i (.SYS_CLK(sys_clk), .RST_B(rst_b), .PERIPH_FLAG(flag),
    .PERIPH_EN(en), .EXT_PIN(pin), .EXT_PIN_EN(pin_en), .EXT_EDGE_MODE(edge_md),
    .INSTR(instr), .CC_POP_DATA(pop_cc), .PRIO_WE(we), .PRIO_IDX(idx),
    .PRIO_WDATA(wdata), .PRIO_RDATA(rdata), .CC(cc), .STALL(stall), .PUSH_REQ(push),
    .PUSH_SEL(psel), .VEC_LOAD(vload), .VEC_ADDR(vaddr), .SLEEPING(sleeping), .PEND(pend));
  npic_core_mdl npic_core_mdl_i (.clk(sys_clk), .stall(stall), .instr(instr));
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  // vector of the next entry, zero if none within 40 cycles
  task automatic wvec(output logic [15:0] v);
    v = 16'h0;
    repeat (40) begin
      @(negedge sys_clk);
      if (vload === 1'b1) begin
        v = vaddr;
        return;
      end
    end
  endtask
  task automatic take(input logic [7:0] op, input logic [15:0] exp);
    logic [15:0] v;
    npic_core_mdl_i.exec(op);
    wvec(v);
    chk(v, exp);
  endtask
  task automatic wr(input logic [1:0] i, input logic [7:0] d, input logic [7:0] exp);
    @(posedge sys_clk);
    we <= 1'b1;
    idx <= i;
    wdata <= d;
    @(posedge sys_clk);
    we <= 1'b0;
    @(negedge sys_clk);
    chk(rdata, exp);
  endtask
  task automatic req(input int k, input logic v);
    @(posedge sys_clk);
    flag[k] <= v;
    en[k] <= v;
    pin[4*k] <= v;
    pin_en[4*k] <= v;
    // external lines pass three flops before the request shows
    if (k >= 1 && k <= 4) repeat (4) @(posedge sys_clk);
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk);
      idx <= 2'(i);
      @(negedge sys_clk);
      chk(rdata, PRIO_RESET);
    end
    repeat (4) @(posedge sys_clk);
    chk(cc, CC_RESET);
    rst_b <= 1'b1;
    wvec(a);
    chk(a, VEC_RESET);
  endtask
  task automatic t_prio();
    wr(2'd0, 8'hcf, 8'hcf);
    wr(2'd0, 8'h64, 8'h44);
    wr(2'd3, 8'h00, 8'hf0);
  endtask
  // idx2 level 2, idx1 and idx3 level 1 from here on
  task automatic t_nest();
    req(2, 1'b1);
    take(8'h20, 16'h0);
    chk(pend[2], 1'b1);
    req(1, 1'b1);
    req(3, 1'b1);
    npic_core_mdl_i.exec(8'h40);
    take(8'h00, 16'hfff6);
    chk({cc[5], cc[3]}, LVL2_CODE);
    take(8'h00, 16'h0);
    req(2, 1'b0);
    take(8'h04, 16'h0);
    chk(cc, 8'he2);
    take(8'h00, 16'hfff8);
    @(posedge sys_clk);
    flag[9] <= 1'b1;
    @(negedge sys_clk);
    chk(pend[9], 1'b0);
    en[9] <= 1'b1;
    @(negedge sys_clk);
    chk(pend[9], 1'b1);
    flag[9] <= 1'b0;
    @(negedge sys_clk);
    chk(pend[9], 1'b0);
    take(8'h02, VEC_TRAP);
    chk({cc[5], cc[3]}, LVL3_CODE);
    req(1, 1'b0);
    req(3, 1'b0);
    take(8'h04, 16'h0);
  endtask
  // slow core here; edge latch must outlive the pin pulse
  task automatic t_ext();
    npic_core_mdl_i.gap = 3;
    @(posedge sys_clk);
    edge_md[1] <= 1'b1;
    pin_en[7:4] <= 4'hf;
    pin[6] <= 1'b1;
    repeat (2) @(posedge sys_clk);
    pin[6] <= 1'b0;
    repeat (6) @(posedge sys_clk);
    @(negedge sys_clk);
    chk(pend[1], 1'b1);
    take(8'h00, 16'hfff8);
    chk(pend[1], 1'b0);
    npic_core_mdl_i.gap = 0;
    take(8'h04, 16'h0);
  endtask
  task automatic t_sleep();
    take(8'h08, 16'h0);
    req(6, 1'b1);
    repeat (10) @(posedge sys_clk);
    chk(sleeping, 1'b1);
    req(7, 1'b1);
    wvec(a);
    chk(a, 16'hffec);
    req(7, 1'b0);
    take(8'h04, 16'h0);
    take(8'h00, 16'hffee);
    req(6, 1'b0);
    take(8'h04, 16'h0);
    take(8'h10, 16'h0);
    req(8, 1'b1);
    wvec(a);
    chk(a, 16'hffea);
  endtask
  // second reset in mid-run re-enters through the reset vector
  task automatic t_rerun();
    @(posedge sys_clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    chk(cc, CC_RESET);
    chk(vaddr, VEC_TOP);
    @(posedge sys_clk);
    rst_b <= 1'b1;
    wvec(a);
    chk(a, VEC_RESET);
  endtask
  initial begin
    t_reset();
    t_prio();
    t_nest();
    t_ext();
    t_sleep();
    t_rerun();
    test_done();
  end
  // watchdog far beyond the few hundred cycles the run needs
  initial begin
    #100000;
    err_total++;
    test_done();
  end
endmodule
